// ---- hdl/cctiod_top.sv ----
// descriptor decoder for config timing and io space fields, with access check
// Functional notes
// - timing field starts with scale byte, then extended speed-code bytes
// - scales are power-of-ten multipliers; wait scale applies to wait time
// - wait scale 3 means wait unused, no wait speed bytes
// - ready scale 7 means ready unused, no busy-time bytes
// - reserved scale 7 means no reserved speed bytes
// - present timings follow in order wait, ready, reserved
// - io entry has definition byte; range bit adds descriptor and ranges
// - each range holds start, length or both; several windows allowed
// - byte-only code 01: byte accesses on low lane only
// - code 10: width must match register width, odd byte any lane
// - code 10: word register indication tells host register width
// - code 11: any width unless eight-bit select set, then byte-only
// - range clear: definition byte alone, card decodes its own lines
// - line count 1..26 decoded by card; 27..31 reserved
`timescale 1ns/10ps
module cctiod_top
  import cctiod_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // descriptor byte stream
  input wire logic TIMING_PRESENT_I,
  input wire logic IO_PRESENT_I,
  input wire logic START_I,
  input cctiod_pkg::cctiod_byte_s DESC_I,
  // io access port
  input cctiod_pkg::cctiod_access_s ACC_I,
  input wire logic EIGHT_BIT_HOST_SELECT_I,
  // decoded results
  output cctiod_pkg::cctiod_timing_s TIMING_O,
  output cctiod_pkg::cctiod_io_s IO_O,
  output logic [7:0] WAIT_SPEED_O,
  output logic [7:0] READY_SPEED_O,
  output logic DONE_O,
  output logic ERROR_O,
  output logic ACC_ACCEPT_O,
  output logic ACC_REJECT_O,
  output logic WIDTH16_N_O
);

  // ==========================================================================
  // parse state
  typedef enum logic [3:0] {
    ST_IDLE, ST_SCALE, ST_WAIT, ST_READY, ST_RSVD, ST_IODEF, ST_RDESC, ST_RANGE, ST_DONE
  } cctiod_state_e;

  cctiod_state_e state_r;
  cctiod_state_e state_nxt;
  logic io_want_r;
  logic [4:0] ranges_left_r;
  logic [3:0] bytes_left_r;
  logic [3:0] range_len_r;
  logic first_speed_r;
  logic [7:0] b;
  logic ext;

  assign b = DESC_I.data;
  assign ext = b[SPEED_EXT_BIT];

  // byte count for a size code of 0, 1, 2 or 4 bytes
  function automatic logic [3:0] size_bytes(input logic [1:0] code);
    size_bytes = (code == 2'h3) ? 4'h4 : {2'h0, code};
  endfunction : size_bytes

  // next state after the timing stage has finished with a given field
  function automatic cctiod_state_e after_timing(input logic want_io);
    after_timing = want_io ? ST_IODEF : ST_DONE;
  endfunction : after_timing

  // both size fields zero leaves no range bytes to count, so the parse must end there
  function automatic logic no_sizes(input logic [7:0] rd);
    no_sizes = rd[RD_ASIZE_LSB +: 2] == 2'h0 && rd[RD_LSIZE_LSB +: 2] == 2'h0;
  endfunction : no_sizes

  // ==========================================================================
  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (START_I)
          state_nxt = TIMING_PRESENT_I ? ST_SCALE : (IO_PRESENT_I ? ST_IODEF : ST_DONE);
      ST_SCALE:
        if (DESC_I.valid)
        begin
          if (b[WAIT_SCALE_LSB +: 2] != WAIT_UNUSED)
            state_nxt = ST_WAIT;
          else if (b[READY_SCALE_LSB +: 3] != READY_UNUSED)
            state_nxt = ST_READY;
          else if (b[RSVD_SCALE_LSB +: 3] != RSVD_UNUSED)
            state_nxt = ST_RSVD;
          else
            state_nxt = after_timing(io_want_r);
        end
      ST_WAIT:
        if (DESC_I.valid && !ext)
        begin
          if (TIMING_O.ready_used)
            state_nxt = ST_READY;
          else if (TIMING_O.rsvd_used)
            state_nxt = ST_RSVD;
          else
            state_nxt = after_timing(io_want_r);
        end
      ST_READY:
        if (DESC_I.valid && !ext)
          state_nxt = TIMING_O.rsvd_used ? ST_RSVD : after_timing(io_want_r);
      ST_RSVD:
        if (DESC_I.valid && !ext)
          state_nxt = after_timing(io_want_r);
      ST_IODEF:
        if (DESC_I.valid)
          state_nxt = b[RANGE_BIT] ? ST_RDESC : ST_DONE;
      ST_RDESC:
        if (DESC_I.valid)
          state_nxt = no_sizes(b) ? ST_DONE : ST_RANGE;
      ST_RANGE:
        if (DESC_I.valid && bytes_left_r == 4'h1 && ranges_left_r == 5'h0)
          state_nxt = ST_DONE;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      io_want_r <= 1'b0;
    else if (state_r == ST_IDLE && START_I)
      io_want_r <= IO_PRESENT_I;
  end

  // ==========================================================================
  // timing field capture
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      TIMING_O <= '0;
    else if (state_r == ST_SCALE && DESC_I.valid)
    begin
      TIMING_O.wait_scale <= b[WAIT_SCALE_LSB +: 2];
      TIMING_O.ready_scale <= b[READY_SCALE_LSB +: 3];
      TIMING_O.rsvd_scale <= b[RSVD_SCALE_LSB +: 3];
      TIMING_O.wait_used <= b[WAIT_SCALE_LSB +: 2] != WAIT_UNUSED;
      TIMING_O.ready_used <= b[READY_SCALE_LSB +: 3] != READY_UNUSED;
      TIMING_O.rsvd_used <= b[RSVD_SCALE_LSB +: 3] != RSVD_UNUSED;
    end
  end

  // only the first speed byte of the wait and ready times is kept; extensions and reserved speed bytes are skipped
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      first_speed_r <= 1'b1;
    else if (DESC_I.valid && (state_r == ST_WAIT || state_r == ST_READY || state_r == ST_RSVD))
      first_speed_r <= !ext;
    else if (state_r == ST_SCALE)
      first_speed_r <= 1'b1;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      WAIT_SPEED_O <= 8'h00;
      READY_SPEED_O <= 8'h00;
    end
    else if (DESC_I.valid && first_speed_r)
    begin
      if (state_r == ST_WAIT)
        WAIT_SPEED_O <= b;
      if (state_r == ST_READY)
        READY_SPEED_O <= b;
    end
  end

  // ==========================================================================
  // io space capture
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      IO_O <= '{range_present: 1'b0, width: WIDTH_RSVD, line_count: 5'h00, lines_bad: 1'b0, range_count: 5'h00};
    else if (state_r == ST_IODEF && DESC_I.valid)
    begin
      IO_O.range_present <= b[RANGE_BIT];
      IO_O.width <= cctiod_width_e'(b[WIDTH_LSB +: 2]);
      IO_O.line_count <= b[LINES_LSB +: 5];
      IO_O.lines_bad <= b[LINES_LSB +: 5] > LINES_MAX;
      IO_O.range_count <= 5'h00;
    end
    else if (state_r == ST_RDESC && DESC_I.valid)
      IO_O.range_count <= {1'b0, b[RD_COUNT_LSB +: 4]} + 5'h01;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      ranges_left_r <= 5'h00;
      bytes_left_r <= 4'h0;
      range_len_r <= 4'h0;
    end
    else if (state_r == ST_RDESC && DESC_I.valid)
    begin
      ranges_left_r <= {1'b0, b[RD_COUNT_LSB +: 4]};
      range_len_r <= size_bytes(b[RD_ASIZE_LSB +: 2]) + size_bytes(b[RD_LSIZE_LSB +: 2]);
      bytes_left_r <= size_bytes(b[RD_ASIZE_LSB +: 2]) + size_bytes(b[RD_LSIZE_LSB +: 2]);
    end
    else if (state_r == ST_RANGE && DESC_I.valid)
    begin
      if (bytes_left_r == 4'h1)
      begin
        bytes_left_r <= range_len_r;
        ranges_left_r <= ranges_left_r - 5'h01;
      end
      else
        bytes_left_r <= bytes_left_r - 4'h1;
    end
  end

  // ==========================================================================
  // completion and errors
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      DONE_O <= 1'b0;
    else
      DONE_O <= (state_r == ST_DONE);
  end

  // flags a reserved width, reserved line count, or both size fields zero
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      ERROR_O <= 1'b0;
    else if (state_r == ST_IDLE && START_I)
      ERROR_O <= 1'b0;
    else if (state_r == ST_IODEF && DESC_I.valid)
      ERROR_O <= b[WIDTH_LSB +: 2] == WIDTH_RSVD || b[LINES_LSB +: 5] > LINES_MAX;
    else if (state_r == ST_RDESC && DESC_I.valid && no_sizes(b))
      ERROR_O <= 1'b1;
  end

  // ==========================================================================
  // access width check; host splitting of word accesses is relied on
  cctiod_access u_access (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .width_i(IO_O.width),
    .eight_bit_host_select_i(EIGHT_BIT_HOST_SELECT_I),
    .acc_i(ACC_I),
    .accept_o(ACC_ACCEPT_O),
    .reject_o(ACC_REJECT_O),
    .width16_n_o(WIDTH16_N_O)
  );

endmodule : cctiod_top

// ---- hdl/cctiod_pkg.sv ----
// package of constants and types for the card config timing and io decoder
package cctiod_pkg;

  // ==========================================================================
  // timing scale and speed byte layout
  localparam int WAIT_SCALE_LSB = 0;
  localparam int READY_SCALE_LSB = 2;
  localparam int RSVD_SCALE_LSB = 5;
  localparam logic [1:0] WAIT_UNUSED = 2'h3;
  localparam logic [2:0] READY_UNUSED = 3'h7;
  localparam logic [2:0] RSVD_UNUSED = 3'h7;
  localparam int SPEED_EXT_BIT = 7;

  // ==========================================================================
  // io space definition and range descriptor byte layout
  localparam int RANGE_BIT = 7;
  localparam int WIDTH_LSB = 5;
  localparam int LINES_LSB = 0;
  localparam logic [4:0] LINES_MAX = 5'h1A;
  localparam int RD_COUNT_LSB = 0;
  localparam int RD_ASIZE_LSB = 4;
  localparam int RD_LSIZE_LSB = 6;

  // ==========================================================================
  // bus width codes
  typedef enum logic [1:0] {
    WIDTH_RSVD = 2'h0,
    WIDTH_BYTE = 2'h1,
    WIDTH_STRICT = 2'h2,
    WIDTH_DUAL = 2'h3
  } cctiod_width_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } cctiod_byte_s;

  typedef struct packed {
    logic [1:0] wait_scale;
    logic [2:0] ready_scale;
    logic [2:0] rsvd_scale;
    logic wait_used;
    logic ready_used;
    logic rsvd_used;
  } cctiod_timing_s;

  typedef struct packed {
    logic range_present;
    cctiod_width_e width;
    logic [4:0] line_count;
    logic lines_bad;
    logic [4:0] range_count;
  } cctiod_io_s;

  typedef struct packed {
    logic valid;
    logic is_word;
    logic reg_is_word;
    logic high_lane;
  } cctiod_access_s;

endpackage : cctiod_pkg

// ---- hdl/cctiod_access.sv ----
// access width checker for the io bus width modes
`timescale 1ns/10ps
module cctiod_access
  import cctiod_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input cctiod_pkg::cctiod_width_e width_i,
  input wire logic eight_bit_host_select_i,
  input cctiod_pkg::cctiod_access_s acc_i,
  output logic accept_o,
  output logic reject_o,
  output logic width16_n_o
);

  logic ok;

  always_comb
  begin
    ok = 1'b0;
    case (width_i)
      WIDTH_BYTE: ok = !acc_i.is_word && !acc_i.high_lane;
      WIDTH_STRICT: ok = (acc_i.is_word == acc_i.reg_is_word);
      WIDTH_DUAL:
        if (eight_bit_host_select_i)
          ok = !acc_i.is_word && !acc_i.high_lane;
        else
          ok = 1'b1;
      default: ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      accept_o <= 1'b0;
      reject_o <= 1'b0;
    end
    else
    begin
      accept_o <= acc_i.valid && ok;
      reject_o <= acc_i.valid && !ok;
    end
  end

  // word register indication, active low, only meaningful in strict mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      width16_n_o <= 1'b1;
    else
      width16_n_o <= !(acc_i.valid && width_i == WIDTH_STRICT && acc_i.reg_is_word);
  end

endmodule : cctiod_access

// ---- tb/cctiod_host_model.sv ----
// host socket controller model that issues card io cycles
`timescale 1ns/10ps
module cctiod_host_model
  import cctiod_pkg::*;
(
  // clock and request
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic raw_i,
  input wire logic host8_i,
  input cctiod_pkg::cctiod_access_s req_i,
  input cctiod_pkg::cctiod_width_e width_i,
  // card side
  output cctiod_pkg::cctiod_access_s acc_o,
  output logic sel_o
);
  logic second_r = 1'b0;
  logic reg_word_r = 1'b0;
  logic split;
  cctiod_access_s acc_r = '0;
  assign acc_o = acc_r;
  assign sel_o = host8_i;
  assign split = go_i && !raw_i && req_i.is_word && (width_i == WIDTH_BYTE || host8_i);
  // ==========================================================================
  // cycle generation
  always @(posedge clk_i)
  begin
    second_r <= split && !second_r;
    if (second_r)
      acc_r <= {2'h2, reg_word_r, 1'b0};
    else if (split)
    begin
      acc_r <= {2'h2, req_i.reg_is_word, 1'b0};
      reg_word_r <= req_i.reg_is_word;
    end
    else if (go_i && !raw_i && width_i == WIDTH_STRICT)
      acc_r <= {1'b1, req_i.reg_is_word, req_i.reg_is_word, req_i.high_lane};
    else if (go_i)
      acc_r <= req_i;
    else
      // idle fields flip so that a stale access is never mistaken for a fresh one
      acc_r <= {1'b0, ~acc_r[2:0]};
  end
endmodule : cctiod_host_model

// ---- tb/cctiod_top_checker.sv ----
// port checker for the descriptor decoder and access checker
`timescale 1ns/10ps
module cctiod_top_checker
  import cctiod_pkg::*;
(
  // watched ports
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input cctiod_pkg::cctiod_access_s ACC_I,
  input wire logic EIGHT_BIT_HOST_SELECT_I,
  input cctiod_pkg::cctiod_timing_s TIMING_O,
  input cctiod_pkg::cctiod_io_s IO_O,
  input wire logic DONE_O,
  input wire logic ACC_ACCEPT_O,
  input wire logic ACC_REJECT_O,
  input wire logic WIDTH16_N_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  logic v;
  cctiod_width_e wd;
  assign v = ACC_I.valid;
  assign wd = IO_O.width;
  logic byte_mode;
  assign byte_mode = wd == WIDTH_BYTE || (wd == WIDTH_DUAL && EIGHT_BIT_HOST_SELECT_I);
  // ==========================================================================
  // properties
  property p_one_answer; v |=> ACC_ACCEPT_O != ACC_REJECT_O; endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("access without a single answer");
  property p_byte_only; v && byte_mode && !ACC_I.is_word && !ACC_I.high_lane |=> ACC_ACCEPT_O; endproperty
  a_byte_only: assert property (p_byte_only)
    else $error("byte-only access refused");
  property p_byte_refuse; v && byte_mode && (ACC_I.is_word || ACC_I.high_lane) |=> ACC_REJECT_O; endproperty
  a_byte_refuse: assert property (p_byte_refuse)
    else $error("byte-only mode accepted a word or high lane access");
  property p_strict; v && wd == WIDTH_STRICT && ACC_I.is_word == ACC_I.reg_is_word |=> ACC_ACCEPT_O; endproperty
  a_strict: assert property (p_strict)
    else $error("strict width matching access refused");
  property p_strict_refuse; v && wd == WIDTH_STRICT && ACC_I.is_word != ACC_I.reg_is_word |=> ACC_REJECT_O;
  endproperty
  a_strict_refuse: assert property (p_strict_refuse)
    else $error("strict width mismatched access accepted");
  property p_dual; v && wd == WIDTH_DUAL && !EIGHT_BIT_HOST_SELECT_I |=> ACC_ACCEPT_O; endproperty
  a_dual: assert property (p_dual)
    else $error("dual width access refused");
  property p_width_rsvd; v && wd == WIDTH_RSVD |=> ACC_REJECT_O; endproperty
  a_width_rsvd: assert property (p_width_rsvd)
    else $error("access accepted with invalid width");
  property p_word_ind; v && wd == WIDTH_STRICT && ACC_I.reg_is_word |=> !WIDTH16_N_O; endproperty
  a_word_ind: assert property (p_word_ind)
    else $error("word register not indicated");
  property p_lines; DONE_O |-> IO_O.lines_bad == (IO_O.line_count > LINES_MAX); endproperty
  a_lines: assert property (p_lines)
    else $error("line count range flag wrong");
  property p_wait_flag; DONE_O |-> TIMING_O.wait_used == (TIMING_O.wait_scale != WAIT_UNUSED); endproperty
  a_wait_flag: assert property (p_wait_flag)
    else $error("wait use flag wrong");
  property p_ready_flag; DONE_O |-> TIMING_O.ready_used == (TIMING_O.ready_scale != READY_UNUSED); endproperty
  a_ready_flag: assert property (p_ready_flag)
    else $error("ready use flag wrong");
  property p_rsvd_flag; DONE_O |-> TIMING_O.rsvd_used == (TIMING_O.rsvd_scale != RSVD_UNUSED); endproperty
  a_rsvd_flag: assert property (p_rsvd_flag)
    else $error("reserved use flag wrong");
  c_accept: cover property (v ##1 ACC_ACCEPT_O);
  c_reject: cover property (v ##1 ACC_REJECT_O);
  c_word: cover property (!WIDTH16_N_O);
endmodule : cctiod_top_checker
bind cctiod_top cctiod_top_checker chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ACC_I(ACC_I),
  .EIGHT_BIT_HOST_SELECT_I(EIGHT_BIT_HOST_SELECT_I), .TIMING_O(TIMING_O), .IO_O(IO_O), .DONE_O(DONE_O),
  .ACC_ACCEPT_O(ACC_ACCEPT_O), .ACC_REJECT_O(ACC_REJECT_O), .WIDTH16_N_O(WIDTH16_N_O));

// ---- tb/cctiod_top_bench.sv ----
// self-checking bench for the descriptor decoder and access checker
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module cctiod_top_bench;
  import cctiod_pkg::*;
  logic clk = 0, rst = 1, tp = 0, iop = 0, start = 0, go = 0, raw = 0, host8 = 0;
  logic done, err, ac, rj, w16, sel;
  logic [7:0] wsp, rsp, s, d;
  logic [6:0] a;
  logic [7:0] q[$];
  cctiod_byte_s desc = '0;
  cctiod_access_s req = '0, acc;
  cctiod_timing_s tim;
  cctiod_io_s io;
  int n_fail = 0, total_checks = 0;
  // scale byte, definition byte, expected error
  logic [16:0] drow[4] = '{{8'hFF, 8'h41, 1'h0}, {8'hE0, 8'h3A, 1'h0}, {8'h1E, 8'h7B, 1'h1}, {8'h03, 8'h01, 1'h1}};
  // width, select, word, word register, high lane, expected accept
  logic [6:0] arow[10] = '{7'h21, 7'h22, 7'h2C, 7'h4D, 7'h44, 7'h43, 7'h69, 7'h78, 7'h72, 7'h00};
  always #4 clk = ~clk;
  cctiod_top dut (.REF_CLK_I(clk), .RST_I(rst), .TIMING_PRESENT_I(tp), .IO_PRESENT_I(iop), .START_I(start),
    .DESC_I(desc), .ACC_I(acc), .EIGHT_BIT_HOST_SELECT_I(sel), .TIMING_O(tim), .IO_O(io), .WAIT_SPEED_O(wsp),
    .READY_SPEED_O(rsp), .DONE_O(done), .ERROR_O(err), .ACC_ACCEPT_O(ac), .ACC_REJECT_O(rj), .WIDTH16_N_O(w16));
  cctiod_host_model host (.clk_i(clk), .go_i(go), .raw_i(raw), .host8_i(host8), .req_i(req),
    .width_i(io.width), .acc_o(acc), .sel_o(sel));
  // ==========================================================================
  // tasks
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic parse(input logic t, input logic i);
    int k;
    @(posedge clk);
    start <= 1;
    tp <= t;
    iop <= i;
    foreach (q[j])
    begin
      @(posedge clk);
      start <= 0;
      desc <= {1'b1, q[j], j == q.size() - 1};
    end
    @(posedge clk);
    desc <= '0;
    for (k = 0; k < 8 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (k == 8)
    begin
      n_fail++;
      results();
    end
  endtask : parse
  task automatic access(input logic r, input logic h, input logic [3:0] rq);
    @(posedge clk);
    go <= 1;
    raw <= r;
    host8 <= h;
    req <= rq;
    @(posedge clk);
    go <= 0;
    @(posedge clk);
    #1;
  endtask : access
  // ==========================================================================
  // sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    #1;
    `CHK("done", 1'b0, done)
    `CHK("word_ind", 1'b1, w16)
    `CHK("width", 2'h0, io.width)
    $display("reset test done");
    foreach (drow[i])
    begin
      s = drow[i][16:9];
      d = drow[i][8:1];
      q = {s};
      if (s[1:0] != 2'h3)
      begin
        q.push_back(8'h92);
        q.push_back(8'h05);
      end
      if (s[4:2] != 3'h7) q.push_back(8'h23);
      if (s[7:5] != 3'h7) q.push_back(8'h34);
      q.push_back(d);
      parse(1, 1);
      `CHK("wait_used", s[1:0] != 2'h3, tim.wait_used)
      `CHK("ready_used", s[4:2] != 3'h7, tim.ready_used)
      `CHK("rsvd_used", s[7:5] != 3'h7, tim.rsvd_used)
      `CHK("wait_scale", s[1:0], tim.wait_scale)
      `CHK("ready_scale", s[4:2], tim.ready_scale)
      `CHK("rsvd_scale", s[7:5], tim.rsvd_scale)
      `CHK("lines", d[4:0], io.line_count)
      if (s[1:0] != 2'h3) `CHK("wait_speed", 8'h92, wsp)
      if (s[4:2] != 3'h7) `CHK("ready_speed", 8'h23, rsp)
      `CHK("range", 1'b0, io.range_present)
      `CHK("width", d[6:5], io.width)
      `CHK("lines_bad", d[4:0] > LINES_MAX, io.lines_bad)
      `CHK("error", drow[i][0], err)
    end
    $display("decode table done");
    foreach (arow[i])
    begin
      a = arow[i];
      q = {{1'b0, a[6:5], 5'h04}};
      if (io.width !== a[6:5]) parse(0, 1);
      access(1, a[4], {1'b1, a[3:1]});
      `CHK("accept", a[0], ac)
      `CHK("reject", !a[0], rj)
      `CHK("word_ind", !(a[6:5] == 2'h2 && a[2]), w16)
    end
    q = {8'h44};
    parse(0, 1);
    access(0, 0, 4'hA);
    `CHK("strict_host_accept", 1'b1, ac)
    `CHK("strict_host_word_ind", 1'b0, w16)
    $display("access table done");
    for (int h = 0; h < 2; h++)
    begin
      q = {{3'h1 + h[2:0] * 3'h2, 5'h04}};
      parse(0, 1);
      access(0, h[0], 4'hE);
      `CHK("split_first", 1'b1, ac)
      @(posedge clk);
      #1;
      `CHK("split_second", 1'b1, ac)
    end
    $display("split test done");
    q = {8'hC4, 8'h51, 8'h10, 8'h0F, 8'h20, 8'h0F};
    parse(0, 1);
    `CHK("range", 1'b1, io.range_present)
    `CHK("range_err", 1'b0, err)
    `CHK("range_count", 5'h02, io.range_count)
    q = {8'hC4, 8'h00};
    parse(0, 1);
    `CHK("empty_range_err", 1'b1, err)
    $display("range test done");
    results();
  end
endmodule : cctiod_top_bench
